// ===== mwfd_decoder.sv
// Microword format decoder with APB register access and control store
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/10ps
module mwfd_decoder (
    // Clock and reset
    input  wire logic                       CLOCK,
    input  wire logic                       ARST_N,
    // Register bus
    input  wire mwfd_pkg::mwfd_apb_req_type APB_REQ,
    output mwfd_pkg::mwfd_apb_rsp_type      APB_RSP,
    // Datapath controls
    output mwfd_pkg::mwfd_status_type       DECODE,
    output logic [15:0]                     DATA_ADDR,
    output logic [15:0]                     INSTR_ADDR
);
    import mwfd_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic [31:0]      microword;
        logic [7:0]       a_val;
        logic [7:0]       b_reg;
        logic [7:0]       aux_a_source_reg;
        logic [15:0]      cur_addr;
        logic [7:0]       branch_low;
        logic [31:0]      mem_regs;
        logic             load_mode;
        logic [15:0]      data_address_reg;
        logic [15:0]      instr_address_reg;
        mwfd_status_type  dec;
        mwfd_apb_rsp_type rsp;
    } mwfd_state_type;

    mwfd_state_type    s;
    mwfd_state_type    next_s;
    logic [31:0]       cstore [0:(1<<CST_AW)-1];

    logic [31:0]       w;
    logic              take;
    logic              exec;
    logic              load_stmt;
    mwfd_fmt_type      fmt_d;
    logic [1:0]        opf;
    logic [3:0]        cval;
    logic [4:0]        special_execute_op;
    logic [7:0]        c4;
    logic [7:0]        b_opf;
    logic [7:0]        b_val;
    logic [7:0]        hi_keep;
    logic [15:0]       next_dar;
    logic [15:0]       next_iar;
    logic [CST_AW-1:0] idx;
    logic              cst_we;
    logic [CST_AW-1:0] cst_addr;
    logic [31:0]       cst_data;
    logic [31:0]       rd;
    logic              rd_ok;

    assign APB_RSP    = s.rsp;
    assign DECODE     = s.dec;
    assign DATA_ADDR  = s.data_address_reg;
    assign INSTR_ADDR = s.instr_address_reg;

    // ==========================================================
    // Format decode
    always_comb begin
        w       = APB_REQ.pwdata;
        opf     = w[POS_OPF +: 2];
        cval    = w[POS_CONST +: 4];
        special_execute_op = w[POS_SPEXOP +: 5];
        if (w[POS_HIBR +: 4] == NIB_F && w[POS_LOWCTL +: 4] == NIB_F) begin
            fmt_d = FMT_COMBINED;
        end else if (w[POS_LOWCTL +: 4] == NIB_F && w[POS_TAG +: 2] == TAG_SPECIAL) begin
            fmt_d = FMT_SPECIAL;
        end else if (w[POS_HIBR +: 4] == NIB_F && w[POS_LOWCTL +: 4] == NIB_0) begin
            fmt_d = FMT_LOAD_IA;
        end else if (w[POS_MAJOR +: 4] == MAJOR_STORE) begin
            fmt_d = FMT_STORE4;
        end else if (w[POS_MAJOR +: 4] == MAJOR_FETCH) begin
            fmt_d = FMT_FETCH4;
        end else begin
            fmt_d = FMT_NONE;
        end
        // Four-bit constant, bit 19 picks the half
        c4 = w[POS_BHALF] ? {cval, 4'h0} : {4'h0, cval};
        // B source by operand format; format 1 the 8-bit constant, format 3 the four-bit constant, else constant select zero gives zero, other values the B register
        case (opf)
            OPF_1:   b_opf = w[POS_CONST8 +: 8];
            OPF_3:   b_opf = c4;
            default: b_opf = (cval == NIB_0) ? 8'h00 : s.b_reg;
        endcase
        if (fmt_d == FMT_FETCH4 || fmt_d == FMT_STORE4) begin
            b_val = c4;
        end else begin
            b_val = b_opf;
        end
        // Format 2 takes the page field as second character
        if (opf == OPF_2) begin
            hi_keep = {s.cur_addr[15:12], w[POS_PAGEX +: 4]};
        end else begin
            hi_keep = s.cur_addr[15:8];
        end
    end

    // ==========================================================
    // Address building, data address low characters come from A before writeback
    always_comb begin
        next_dar = s.data_address_reg;
        case (fmt_d)
            FMT_FETCH4, FMT_STORE4: begin
                next_dar = {s.data_address_reg[15:12], w[POS_SECTOR +: 4], s.a_val};
            end
            FMT_SPECIAL: begin
                if (special_execute_op == SPECIAL_EXECUTE_QUADRANT) begin
                    next_dar = {b_val[3:0], s.data_address_reg[11:0]};
                end
            end
            default: next_dar = s.data_address_reg;
        endcase
        case (fmt_d)
            FMT_COMBINED: next_iar = {b_val, s.aux_a_source_reg};
            FMT_LOAD_IA:  next_iar = {hi_keep, s.a_val};
            FMT_SPECIAL:  next_iar = {hi_keep, s.branch_low};
            default:      next_iar = {s.cur_addr[15:8], s.branch_low};
        endcase
        idx = next_dar[POS_WORD +: CST_AW];
    end

    // ==========================================================
    // Register bus
    always_comb begin
        take      = APB_REQ.psel & APB_REQ.penable & s.rsp.pready;
        exec      = take & APB_REQ.pwrite & (APB_REQ.paddr == OFS_MICROWORD)
                    & ~s.load_mode & ~s.dec.halted;
        load_stmt = take & APB_REQ.pwrite & (APB_REQ.paddr == OFS_MICROWORD) & s.load_mode;
        rd_ok     = 1'b1;
        case (APB_REQ.paddr)
            OFS_MICROWORD:  rd = s.microword;
            OFS_A_VALUE:    rd = {24'h000000, s.a_val};
            OFS_B_REG:      rd = {24'h000000, s.b_reg};
            OFS_AUX_A:      rd = {24'h000000, s.aux_a_source_reg};
            OFS_CUR_ADDR:   rd = {16'h0000, s.cur_addr};
            OFS_BRANCH_LOW: rd = {24'h000000, s.branch_low};
            OFS_MEM_REGS:   rd = s.mem_regs;
            OFS_CTRL:       rd = {31'h00000000, s.load_mode};
            OFS_DATA_ADDR:  rd = {16'h0000, s.data_address_reg};
            OFS_INSTR_ADDR: rd = {16'h0000, s.instr_address_reg};
            OFS_DECODE:     rd = {3'h0, s.dec};
            OFS_STORE_WORD: rd = cstore[s.cur_addr[CST_AW-1:0]];
            default: begin
                rd    = 32'h00000000;
                rd_ok = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Next state
    always_comb begin
        next_s             = s;
        next_s.rsp.pready  = APB_REQ.psel & APB_REQ.penable & ~s.rsp.pready;
        next_s.rsp.pslverr = 1'b0;
        cst_we             = 1'b0;
        cst_addr           = idx;
        cst_data           = s.mem_regs;
        if (APB_REQ.psel & APB_REQ.penable & ~s.rsp.pready) begin
            next_s.rsp.prdata  = APB_REQ.pwrite ? 32'h00000000 : rd;
            next_s.rsp.pslverr = ~rd_ok;
        end
        if (take & APB_REQ.pwrite) begin
            case (APB_REQ.paddr)
                OFS_MICROWORD:  next_s.microword        = w;
                OFS_A_VALUE:    next_s.a_val            = w[7:0];
                OFS_B_REG:      next_s.b_reg            = w[7:0];
                OFS_AUX_A:      next_s.aux_a_source_reg = w[7:0];
                OFS_CUR_ADDR:   next_s.cur_addr         = w[15:0];
                OFS_BRANCH_LOW: next_s.branch_low       = w[7:0];
                OFS_MEM_REGS:   next_s.mem_regs         = w;
                OFS_CTRL: begin
                    next_s.load_mode = w[CTRL_LOAD_BIT];
                    if (w[CTRL_CLR_HALT]) begin
                        next_s.dec.halted = 1'b0;
                    end
                end
                default: next_s.load_mode = s.load_mode;
            endcase
        end
        if (load_stmt) begin
            // Data statement stored, never decoded
            cst_we            = 1'b1;
            cst_addr          = s.cur_addr[CST_AW-1:0];
            cst_data          = w;
            next_s.cur_addr   = s.cur_addr + 16'h0001;
            next_s.dec.fmt    = FMT_DATA;
        end
        if (exec) begin
            next_s.dec.fmt        = fmt_d;
            next_s.dec.opf        = opf;
            next_s.dec.b_val      = b_val;
            next_s.dec.special_execute_op    = special_execute_op;
            next_s.dec.force_add  = (fmt_d != FMT_LOAD_IA) && (fmt_d != FMT_NONE);
            next_s.dec.supp_a     = (fmt_d == FMT_SPECIAL);
            next_s.dec.supp_d     = (fmt_d == FMT_SPECIAL);
            next_s.dec.a_from_aux = (fmt_d == FMT_COMBINED);
            next_s.dec.store_req  = (fmt_d == FMT_STORE4);
            // Microcode error flag only, behaviour undefined
            next_s.dec.invalid    = (fmt_d == FMT_SPECIAL) && (special_execute_op == SPECIAL_EXECUTE_ADDRLOAD)
                                    && (opf == OPF_2);
            // Program stop word halts the sequencer
            if (fmt_d == FMT_SPECIAL && special_execute_op == SPECIAL_EXECUTE_STOP) begin
                next_s.dec.halted = 1'b1;
            end
            next_s.data_address_reg  = next_dar;
            next_s.instr_address_reg = next_iar;
            next_s.cur_addr          = next_iar;
            if (fmt_d == FMT_FETCH4 || fmt_d == FMT_STORE4) begin
                // ALU writeback after the address latch
                next_s.a_val = s.a_val + b_val;
            end
            if (fmt_d == FMT_FETCH4) begin
                next_s.mem_regs = cstore[idx];
            end
            if (fmt_d == FMT_STORE4) begin
                cst_we = 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            s               <= '0;
            s.dec.fmt       <= FMT_NONE;
        end else begin
            s <= next_s;
        end
    end

    // Control store, not reset
    always_ff @(posedge CLOCK) begin
        if (cst_we) begin
            cstore[cst_addr] <= cst_data;
        end
    end

    // ==========================================================
    // Checks
    a_fetch_dar_low: assert property (
        @(posedge CLOCK) disable iff (!ARST_N)
        exec && fmt_d == FMT_FETCH4 |=> s.data_address_reg[7:0] == $past(s.a_val)
            && s.a_val == 8'($past(s.a_val) + $past(b_val)))
        else $error("fetch did not latch A before writeback");

    a_quadrant_hold: assert property (
        @(posedge CLOCK) disable iff (!ARST_N)
        exec && (fmt_d == FMT_FETCH4 || fmt_d == FMT_STORE4)
        |=> $stable(s.data_address_reg[15:12]))
        else $error("quadrant changed by fetch or store");

    a_quadrant_cause: assert property (
        @(posedge CLOCK) disable iff (!ARST_N)
        $changed(s.data_address_reg[15:12]) |-> $past(exec)
            && $past(fmt_d) == FMT_SPECIAL && $past(special_execute_op) == SPECIAL_EXECUTE_QUADRANT)
        else $error("quadrant changed without op 04");

    a_store_decode: assert property (
        @(posedge CLOCK) disable iff (!ARST_N)
        exec && w[POS_MAJOR +: 4] == MAJOR_STORE && w[POS_HIBR +: 4] != NIB_F
            && w[POS_LOWCTL +: 4] != NIB_F
        |=> s.dec.fmt == FMT_STORE4 && s.dec.store_req && s.dec.force_add)
        else $error("store pattern not decoded");

    a_store_write: assert property (
        @(posedge CLOCK) disable iff (!ARST_N)
        exec && fmt_d == FMT_STORE4 |=> cstore[$past(idx)] == $past(s.mem_regs))
        else $error("store did not write memory registers");

    a_store_bhalf: assert property (
        @(posedge CLOCK) disable iff (!ARST_N)
        exec && fmt_d == FMT_STORE4 && w[POS_BHALF]
        |=> s.dec.b_val[3:0] == 4'h0 && s.dec.b_val[7:4] == $past(cval))
        else $error("store constant in wrong half");

    a_special_gate: assert property (
        @(posedge CLOCK) disable iff (!ARST_N)
        exec && fmt_d == FMT_SPECIAL |=> s.dec.supp_a && s.dec.supp_d
            && s.dec.special_execute_op == $past(special_execute_op) && $stable(s.a_val))
        else $error("special execute gating wrong");

    a_loadia_addr: assert property (
        @(posedge CLOCK) disable iff (!ARST_N)
        exec && fmt_d == FMT_LOAD_IA |=> s.instr_address_reg[7:0] == $past(s.a_val)
            && s.instr_address_reg[15:12] == $past(s.cur_addr[15:12]))
        else $error("address load low characters wrong");

    a_combined_addr: assert property (
        @(posedge CLOCK) disable iff (!ARST_N)
        exec && fmt_d == FMT_COMBINED
        |=> s.instr_address_reg == {$past(b_val), $past(s.aux_a_source_reg)}
            && s.dec.a_from_aux)
        else $error("combined form address wrong");

    a_one_format: assert property (
        @(posedge CLOCK) disable iff (!ARST_N)
        $onehot(s.dec.fmt))
        else $error("decoded format not one-hot");

endmodule

// ===== mwfd_pkg.sv
// Constants, types and register layout for the microword format decoder
package mwfd_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [11:0] OFS_MICROWORD  = 12'h000;
    localparam logic [11:0] OFS_A_VALUE    = 12'h004;
    localparam logic [11:0] OFS_B_REG      = 12'h008;
    localparam logic [11:0] OFS_AUX_A      = 12'h00C;
    localparam logic [11:0] OFS_CUR_ADDR   = 12'h010;
    localparam logic [11:0] OFS_BRANCH_LOW = 12'h014;
    localparam logic [11:0] OFS_MEM_REGS   = 12'h018;
    localparam logic [11:0] OFS_CTRL       = 12'h01C;
    localparam logic [11:0] OFS_DATA_ADDR  = 12'h020;
    localparam logic [11:0] OFS_INSTR_ADDR = 12'h024;
    localparam logic [11:0] OFS_DECODE     = 12'h028;
    localparam logic [11:0] OFS_STORE_WORD = 12'h02C;
    localparam int          CTRL_LOAD_BIT  = 0;
    localparam int          CTRL_CLR_HALT  = 1;

    // ==========================================================
    // Microword fields, vector bit = 31 - printed bit
    localparam int POS_MAJOR   = 0;
    localparam int POS_OPF     = 0;
    localparam int POS_TAG     = 2;
    localparam int POS_LOWCTL  = 4;
    localparam int POS_HIBR    = 8;
    localparam int POS_BHALF   = 12;
    localparam int POS_SPEXOP  = 16;
    localparam int POS_SECTOR  = 20;
    localparam int POS_CONST   = 24;
    localparam int POS_CONST8  = 24;
    localparam int POS_PAGEX   = 28;
    localparam int POS_WORD    = 2;
    localparam int CST_AW      = 12;

    // ==========================================================
    // Codes
    localparam logic [3:0]  MAJOR_STORE   = 4'hE;
    localparam logic [3:0]  MAJOR_FETCH   = 4'hC;
    localparam logic [1:0]  TAG_SPECIAL   = 2'h1;
    localparam logic [3:0]  NIB_F         = 4'hF;
    localparam logic [3:0]  NIB_0         = 4'h0;
    localparam logic [1:0]  OPF_1         = 2'h2;
    localparam logic [1:0]  OPF_2         = 2'h0;
    localparam logic [1:0]  OPF_3         = 2'h3;
    localparam logic [4:0]  SPECIAL_EXECUTE_QUADRANT = 5'h04;
    localparam logic [4:0]  SPECIAL_EXECUTE_ADDRLOAD = 5'h05;
    localparam logic [4:0]  SPECIAL_EXECUTE_STOP     = 5'h0F;
    localparam logic [31:0] PROGRAM_STOP  = 32'h000F00F4;

    typedef enum logic [6:0] {
        FMT_NONE     = 7'h01,
        FMT_FETCH4   = 7'h02,
        FMT_STORE4   = 7'h04,
        FMT_SPECIAL  = 7'h08,
        FMT_LOAD_IA  = 7'h10,
        FMT_COMBINED = 7'h20,
        FMT_DATA     = 7'h40
    } mwfd_fmt_type;

    typedef struct packed {
        logic [4:0]   special_execute_op;
        logic         halted;
        logic         invalid;
        logic         store_req;
        logic         a_from_aux;
        logic         supp_d;
        logic         supp_a;
        logic         force_add;
        logic [7:0]   b_val;
        logic [1:0]   opf;
        mwfd_fmt_type fmt;
    } mwfd_status_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } mwfd_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } mwfd_apb_rsp_type;

endpackage

// ===== mwfd_store_model.sv
// Microcode source model standing in for the control store image
`timescale 1ns/10ps
module mwfd_store_model
    import mwfd_pkg::*;
(
    // Selection of the program word
    input  wire logic [3:0]  SEL,
    // Microword handed to the decoder
    output logic      [31:0] WORD
);
    // ==========================================================
    // Program image
    always_comb begin
        case (SEL)
            4'h0:    WORD = 32'h0350000C;
            4'h1:    WORD = 32'h0170100E;
            4'h2:    WORD = 32'h090400F6;
            4'h3:    WORD = 32'hA0000F00;
            4'h4:    WORD = 32'h00000F02;
            4'h5:    WORD = 32'h7E000FF6;
            // Deliberately broken word, only selected to provoke the flag
            4'h7:    WORD = 32'h000500F4;
            // Special execute under operand formats 3 and 4
            4'h8:    WORD = 32'h050110F7;
            4'h9:    WORD = 32'h020100F5;
            // Fetch from sector 7
            4'hA:    WORD = 32'h0370000C;
            // Unused slots hold the stop word
            default: WORD = PROGRAM_STOP;
        endcase
    end
endmodule

// ===== microword_format_decoder_test.sv
// Self-checking testbench for the microword format decoder
`timescale 1ns/10ps
module microword_format_decoder_test
    import mwfd_pkg::*;
;
    // ==========================================================
    // Signals
    logic             clock = 1'h0;
    logic             arst_n = 1'h0;
    mwfd_apb_req_type apb_req = '0;
    mwfd_apb_rsp_type apb_rsp;
    mwfd_status_type  decode;
    logic [15:0]      data_addr;
    logic [15:0]      instr_addr;
    logic [3:0]       sel = 4'h0;
    logic [31:0]      word;
    int               n_fail = 0;
    int               n_tests = 0;
    int               cycles = 0;

    always #4 clock = ~clock;

    mwfd_decoder i_dut (
        .CLOCK      (clock),
        .ARST_N     (arst_n),
        .APB_REQ    (apb_req),
        .APB_RSP    (apb_rsp),
        .DECODE     (decode),
        .DATA_ADDR  (data_addr),
        .INSTR_ADDR (instr_addr)
    );

    mwfd_store_model i_store (
        .SEL  (sel),
        .WORD (word)
    );

    // ==========================================================
    // Reporting
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask

    // ==========================================================
    // Bus access
    task automatic apb(input logic wr_en, input logic [11:0] adr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clock);
        apb_req <= '{psel: 1'h1, penable: 1'h0, pwrite: wr_en, paddr: adr, pwdata: wd};
        @(posedge clock);
        apb_req.penable <= 1'h1;
        do @(posedge clock); while (apb_rsp.pready !== 1'h1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
        #1;
    endtask

    task automatic wr(input logic [11:0] adr, input logic [31:0] wd);
        logic [31:0] rd;
        logic        err;
        apb(1'h1, adr, wd, rd, err);
    endtask

    task automatic rdchk(input logic [11:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'h0, adr, 32'h0, rd, err);
        chk(rd, exp);
    endtask

    task automatic exec(input logic [3:0] idx);
        sel = idx;
        #1;
        wr(OFS_MICROWORD, word);
    endtask

    task automatic fmt_is(input mwfd_fmt_type f);
        chk({25'h0, decode.fmt}, {25'h0, f});
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_fetch();
        chk({16'h0, data_addr}, 32'h0);
        fmt_is(FMT_NONE);
        wr(OFS_A_VALUE, 32'h12);
        wr(OFS_CUR_ADDR, 32'h1234);
        wr(OFS_BRANCH_LOW, 32'h56);
        exec(4'h0);
        fmt_is(FMT_FETCH4);
        chk({16'h0, data_addr}, 32'h0512);
        chk({16'h0, instr_addr}, 32'h1256);
        rdchk(OFS_A_VALUE, 32'h15);
    endtask

    task automatic t_store();
        wr(OFS_MEM_REGS, 32'hCAFEF00D);
        exec(4'h1);
        fmt_is(FMT_STORE4);
        chk({16'h0, data_addr}, 32'h0715);
        chk({24'h0, decode.b_val}, 32'h10);
        chk({31'h0, decode.force_add}, 32'h1);
        chk({31'h0, decode.store_req}, 32'h1);
        chk({16'h0, instr_addr}, 32'h1256);
        rdchk(OFS_A_VALUE, 32'h25);
        wr(OFS_CUR_ADDR, 32'h01C5);
        rdchk(OFS_STORE_WORD, 32'hCAFEF00D);
    endtask

    task automatic t_quadrant();
        exec(4'h2);
        fmt_is(FMT_SPECIAL);
        chk({27'h0, decode.special_execute_op}, 32'h4);
        chk({24'h0, decode.b_val}, 32'h09);
        chk({30'h0, decode.opf}, 32'h2);
        chk({29'h0, decode.supp_a, decode.supp_d, decode.force_add}, 32'h7);
        chk({16'h0, data_addr}, 32'h9715);
        exec(4'h0);
        chk({16'h0, data_addr}, 32'h9525);
    endtask

    task automatic t_addr_load();
        wr(OFS_A_VALUE, 32'h3C);
        wr(OFS_CUR_ADDR, 32'h1234);
        exec(4'h3);
        fmt_is(FMT_LOAD_IA);
        chk({16'h0, instr_addr}, 32'h1A3C);
        wr(OFS_CUR_ADDR, 32'h1234);
        exec(4'h4);
        chk({16'h0, instr_addr}, 32'h123C);
    endtask

    task automatic t_combined();
        wr(OFS_AUX_A, 32'h4D);
        exec(4'h5);
        fmt_is(FMT_COMBINED);
        chk({16'h0, instr_addr}, 32'h7E4D);
        chk({31'h0, decode.a_from_aux}, 32'h1);
    endtask

    task automatic t_operand_formats();
        wr(OFS_CUR_ADDR, 32'h2345);
        exec(4'h8);
        chk({24'h0, decode.b_val}, 32'h50);
        chk({30'h0, decode.opf}, 32'h3);
        chk({16'h0, instr_addr}, 32'h2356);
        wr(OFS_B_REG, 32'h6A);
        exec(4'h9);
        chk({24'h0, decode.b_val}, 32'h6A);
        chk({30'h0, decode.opf}, 32'h1);
        wr(OFS_MEM_REGS, 32'h13579BDF);
        wr(OFS_A_VALUE, 32'h40);
        exec(4'h1);
        chk({16'h0, data_addr}, 32'h9740);
        wr(OFS_MEM_REGS, 32'h0);
        wr(OFS_A_VALUE, 32'h40);
        exec(4'hA);
        chk({16'h0, data_addr}, 32'h9740);
        rdchk(OFS_MEM_REGS, 32'h13579BDF);
    endtask

    task automatic t_data_and_stop();
        logic [31:0] rd;
        logic        err;
        wr(OFS_CTRL, 32'h1);
        wr(OFS_CUR_ADDR, 32'h40);
        wr(OFS_MICROWORD, 32'hDEADBEEF);
        fmt_is(FMT_DATA);
        rdchk(OFS_CUR_ADDR, 32'h41);
        wr(OFS_CUR_ADDR, 32'h40);
        rdchk(OFS_STORE_WORD, 32'hDEADBEEF);
        wr(OFS_CTRL, 32'h0);
        exec(4'h7);
        chk({31'h0, decode.invalid}, 32'h1);
        exec(4'h6);
        chk({31'h0, decode.halted}, 32'h1);
        exec(4'h0);
        fmt_is(FMT_SPECIAL);
        wr(OFS_CTRL, 32'h2);
        chk({31'h0, decode.halted}, 32'h0);
        apb(1'h0, 12'h030, 32'h0, rd, err);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge clock);
        arst_n <= 1'h1;
        @(posedge clock);
        #1;
        t_fetch();
        t_store();
        t_quadrant();
        t_addr_load();
        t_combined();
        t_operand_formats();
        t_data_and_stop();
        give_verdict();
    end
endmodule
